// ==== design/ccc_pkg.sv ====
// package of the calendar clock control block
// assumes one 25 MHz core clock and a byte-wide cpu register access
package ccc_pkg;
  // register byte addresses
  localparam logic [19:0] CCC_PRIMARY_ADDR   = 20'hFFF9D;
  localparam logic [19:0] CCC_SECONDARY_ADDR = 20'hFFF9E;
  // primary control fields
  localparam int CCC_RUN_BIT    = 7;
  localparam int CCC_ACC_BIT    = 6;
  localparam int CCC_OUTEN_BIT  = 5;
  localparam int CCC_RSVD_BIT   = 4;
  localparam int CCC_FMT_BIT    = 3;
  localparam int CCC_PER_LSB    = 0;
  // secondary control fields
  localparam int CCC_AMEN_BIT   = 7;
  localparam int CCC_AIEN_BIT   = 6;
  localparam int CCC_TIEN_BIT   = 5;
  localparam int CCC_AHIT_BIT   = 4;
  localparam int CCC_PHIT_BIT   = 3;
  localparam int CCC_ACK_BIT    = 1;
  localparam int CCC_HREQ_BIT   = 0;
  // values after reset
  localparam logic [7:0] CCC_PRIMARY_RST   = 8'h00;
  localparam logic [7:0] CCC_SECONDARY_RST = 8'h00;
  // period select codes
  localparam logic [2:0] CCC_PER_NONE  = 3'h0;
  localparam logic [2:0] CCC_PER_HALF  = 3'h1;
  localparam logic [2:0] CCC_PER_SEC   = 3'h2;
  localparam logic [2:0] CCC_PER_MIN   = 3'h3;
  localparam logic [2:0] CCC_PER_HOUR  = 3'h4;
  localparam logic [2:0] CCC_PER_DAY   = 3'h5;
  // hours codes for midnight in each format and for noon in 12-hour format
  localparam logic [5:0] CCC_MIDNIGHT_12 = 6'h12;
  localparam logic [5:0] CCC_MIDNIGHT_24 = 6'h00;
  localparam logic [5:0] CCC_NOON_12     = 6'h32;
  // sub-second counter marks; the counter steps by two per sub tick so
  // that its 16 bits wrap once a second and bit 15 is a 1 Hz square wave
  localparam logic [15:0] CCC_SUB_STEP = 16'h0002;
  localparam logic [15:0] CCC_SUB_HALF = 16'h7FFE;
  localparam logic [15:0] CCC_SUB_LAST = 16'hFFFE;
  // subsystem clock rate and its enable divider
  localparam int CCC_CORE_CLK_HZ = 25_000_000;
  localparam int CCC_SUB_CLK_HZ  = 32_768;
  localparam int CCC_SUB_DIV     = CCC_CORE_CLK_HZ / CCC_SUB_CLK_HZ;
  // hold handshake states
  typedef enum logic [1:0] {
    CCC_HOLD_RUN   = 2'b00,
    CCC_HOLD_ACC   = 2'b01,
    CCC_HOLD_DRAIN = 2'b10
  } ccc_hold_type;
endpackage

// ==== design/ccc_calendar_ctrl.sv ====
// control and status logic of the calendar clock: control registers,
// sub-second counter, hold handshake, periodic and alarm events
// assumes the time counters sit outside and report their values and carries
`timescale 1ns/1ps
// Notes on behaviour
// [RQ1] run bit gates counting and 1 Hz pin
// [RQ2] format bit picks 12 or 24 hour
// [RQ3] software holds before rewriting hours on format change
// [RQ4] period field picks periodic event rate
// [RQ5] software masks irq around period change
// [RQ6] software writes zero to reserved bit 4
// [RQ7] match enable turns alarm comparison on
// [RQ8] software masks irq around match enable change
// [RQ9] match enable zero while programming alarm
// [RQ10] alarm irq enable gates alarm onto irq
// [RQ11] trim irq enable gates correction tick irq
// [RQ12] alarm flag set one sub tick after match
// [RQ13] period flag set with each periodic event
// [RQ14] writing zero clears flags, one keeps
// [RQ15] software uses byte writes to keep flags
// [RQ16] hold request freezes counters, ack within tick
// [RQ17] ack low counting, high in access mode
// [RQ18] ack stays high until counter write done
// [RQ19] software finishes access within one second
// [RQ20] carry during hold applied after release
// [RQ21] seconds write clears sub counter and carry
// [RQ22] periodic and alarm share one irq
// [RQ23] reset clears secondary register to zero
// [RQ24] 12-hour midnight 12H, noon 32H, bit5 pm
// [RQ25] alarm matches on minute, hour, weekday equal
module ccc_calendar_ctrl
  import ccc_pkg::*;
#(
  parameter int SUB_DIV = CCC_SUB_DIV
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [19:0] bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_bit_wr,
  input  wire logic [2:0]  bus_bit_idx,
  input  wire logic        bus_rd,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata,
  input  wire logic [6:0]  cur_minute,
  input  wire logic [5:0]  cur_hour,
  input  wire logic [2:0]  cur_weekday,
  input  wire logic [6:0]  alarm_minute,
  input  wire logic [5:0]  alarm_hour,
  input  wire logic [2:0]  alarm_weekday,
  input  wire logic        minute_carry,
  input  wire logic        hour_carry,
  input  wire logic        month_carry,
  input  wire logic        seconds_write,
  input  wire logic        counter_write_busy,
  input  wire logic        precise_1hz,
  input  wire logic        trim_tick,
  output logic             seconds_inc,
  output logic             counters_frozen,
  output logic             hour_format_sel,
  output logic             one_hz_pin,
  output logic             clock_irq,
  output logic             trim_tick_irq
);

  // subsystem tick divider state
  logic [15:0]  div_reg, div_next;
  logic         sub_en;
  // control registers
  logic [7:0]   pri_reg, pri_next;
  logic         amen_reg, amen_next, aien_reg, aien_next, tien_reg, tien_next;
  logic         ahit_reg, ahit_next, phit_reg, phit_next, hreq_reg, hreq_next;
  logic [7:0]   sec_rd;
  // time base state
  logic [15:0]  sub_reg, sub_next;
  logic         carry_reg, carry_next;
  logic         sinc_reg, sinc_next;
  ccc_hold_type hold_reg, hold_next;
  logic         eq_reg, eq_next, apend_reg, apend_next;
  logic         hz_reg, hz_next;
  logic         cirq_reg, cirq_next, tirq_reg, tirq_next;
  logic [7:0]   rdata_reg, rdata_next;
  // decoded helpers
  logic         wr_pri, wr_sec, run, overflow, half_evt, period_evt, alarm_set;
  logic         alarm_eq, midnight;
  logic [7:0]   pri_wval, sec_wval;
  logic [2:0]   per_sel;

  // sub clock enable divider; trades exact 32.768 kHz for a whole divide
  always_comb begin
    sub_en   = (div_reg == 16'(SUB_DIV - 1));
    div_next = sub_en ? 16'h0000 : div_reg + 16'h0001;
  end

  // secondary register as software reads it
  always_comb begin
    sec_rd = 8'h00;
    sec_rd[CCC_AMEN_BIT] = amen_reg;
    sec_rd[CCC_AIEN_BIT] = aien_reg;
    sec_rd[CCC_TIEN_BIT] = tien_reg;
    sec_rd[CCC_AHIT_BIT] = ahit_reg;
    sec_rd[CCC_PHIT_BIT] = phit_reg;
    sec_rd[CCC_ACK_BIT]  = (hold_reg != CCC_HOLD_RUN);
    sec_rd[CCC_HREQ_BIT] = hreq_reg;
  end

  // byte writes take the data, bit writes merge into the current value
  always_comb begin
    wr_pri   = (bus_wr || bus_bit_wr) && (bus_addr == CCC_PRIMARY_ADDR);
    wr_sec   = (bus_wr || bus_bit_wr) && (bus_addr == CCC_SECONDARY_ADDR);
    pri_wval = bus_wdata;
    sec_wval = bus_wdata;
    if (bus_bit_wr) begin
      pri_wval = pri_reg;
      pri_wval[bus_bit_idx] = bus_wdata[0];
      sec_wval = sec_rd;
      sec_wval[bus_bit_idx] = bus_wdata[0];
    end
  end

  // control fields steering the time base
  always_comb begin
    run             = pri_reg[CCC_RUN_BIT];
    per_sel         = pri_reg[CCC_PER_LSB +: 3];
    // [RQ2] format select out
    hour_format_sel = pri_reg[CCC_FMT_BIT];
  end

  // [RQ24] midnight code per format
  always_comb begin
    midnight = hour_format_sel ? (cur_hour == CCC_MIDNIGHT_24) : (cur_hour == CCC_MIDNIGHT_12);
  end

  // sub-second counter, carry keeping and seconds increment
  always_comb begin
    sub_next   = sub_reg;
    carry_next = carry_reg;
    sinc_next  = 1'b0;
    overflow   = run && sub_en && (sub_reg == CCC_SUB_LAST);
    half_evt   = run && sub_en && (sub_reg == CCC_SUB_HALF);
    // [RQ1] counting only while run
    if (run && sub_en) begin
      sub_next = sub_reg + CCC_SUB_STEP; // one wrap per second
    end
    // [RQ20] keep carry while held
    if (overflow && (hold_reg != CCC_HOLD_RUN || hreq_reg)) begin
      carry_next = 1'b1;
    end else if (overflow) begin
      sinc_next = 1'b1;
    end else if (carry_reg && sub_en && hold_next == CCC_HOLD_RUN && !hreq_reg) begin
      carry_next = 1'b0;
      sinc_next  = 1'b1;
    end
    // [RQ21] seconds write clears
    if (seconds_write) begin
      sub_next   = 16'h0000;
      carry_next = 1'b0;
      sinc_next  = 1'b0;
    end
  end

  // hold handshake; ack follows the request at the next sub tick
  always_comb begin
    hold_next = hold_reg;
    case (hold_reg)
      // [RQ16] ack within one tick
      CCC_HOLD_RUN: begin
        if (hreq_reg && sub_en) begin
          hold_next = CCC_HOLD_ACC;
        end
      end
      CCC_HOLD_ACC: begin
        if (!hreq_reg && sub_en) begin
          // [RQ18] wait for pending write
          hold_next = counter_write_busy ? CCC_HOLD_DRAIN : CCC_HOLD_RUN;
        end
      end
      CCC_HOLD_DRAIN: begin
        if (hreq_reg && sub_en) begin
          hold_next = CCC_HOLD_ACC;
        end else if (!counter_write_busy && sub_en) begin
          hold_next = CCC_HOLD_RUN;
        end
      end
      default: begin
        hold_next = CCC_HOLD_RUN;
      end
    endcase
  end

  // periodic event selection
  always_comb begin
    // [RQ4] period rate decode
    case (per_sel)
      CCC_PER_NONE: period_evt = 1'b0;
      CCC_PER_HALF: period_evt = half_evt || sinc_reg;
      CCC_PER_SEC:  period_evt = sinc_reg;
      CCC_PER_MIN:  period_evt = minute_carry;
      CCC_PER_HOUR: period_evt = hour_carry;
      CCC_PER_DAY:  period_evt = hour_carry && midnight;
      default:      period_evt = month_carry;
    endcase
  end

  // alarm compare; only a fresh match counts so one match gives one event
  always_comb begin
    // [RQ25] equality compare
    alarm_eq   = (cur_minute == alarm_minute) && (cur_hour == alarm_hour) &&
                 (cur_weekday == alarm_weekday);
    eq_next    = sub_en ? alarm_eq : eq_reg;
    apend_next = apend_reg;
    alarm_set  = 1'b0;
    // [RQ7] compare only when enabled
    if (sub_en && amen_reg && alarm_eq && !eq_reg) begin
      apend_next = 1'b1;
    end else if (sub_en && apend_reg) begin
      // [RQ12] flag one tick later
      apend_next = 1'b0;
      alarm_set  = amen_reg;
    end
  end

  // register writes and flag updates
  always_comb begin
    pri_next  = pri_reg;
    amen_next = amen_reg;
    aien_next = aien_reg;
    tien_next = tien_reg;
    hreq_next = hreq_reg;
    ahit_next = ahit_reg;
    phit_next = phit_reg;
    if (wr_pri) begin
      pri_next = pri_wval;
      pri_next[CCC_RSVD_BIT] = 1'b0;
    end
    if (wr_sec) begin
      amen_next = sec_wval[CCC_AMEN_BIT];
      aien_next = sec_wval[CCC_AIEN_BIT];
      tien_next = sec_wval[CCC_TIEN_BIT];
      hreq_next = sec_wval[CCC_HREQ_BIT];
      // [RQ14] zero clears, one keeps
      ahit_next = ahit_reg && sec_wval[CCC_AHIT_BIT];
      phit_next = phit_reg && sec_wval[CCC_PHIT_BIT];
    end
    // [RQ12] set wins over clear
    if (alarm_set) begin
      ahit_next = 1'b1;
    end
    // [RQ13] period flag set
    if (period_evt) begin
      phit_next = 1'b1;
    end
  end

  // outputs: irq pulses, 1 Hz pin, read data
  always_comb begin
    // [RQ22] shared irq source
    // [RQ10] alarm irq gated
    cirq_next = period_evt || (alarm_set && aien_reg);
    // [RQ11] trim irq gated
    tirq_next = trim_tick && tien_reg;
    // [RQ1] pin only when run and enabled
    if (!run || !pri_reg[CCC_OUTEN_BIT]) begin
      hz_next = 1'b0;
    end else if (pri_reg[CCC_ACC_BIT]) begin
      hz_next = precise_1hz;
    end else begin
      hz_next = sub_reg[15];
    end
    rdata_next = rdata_reg;
    if (bus_rd) begin
      if (bus_addr == CCC_PRIMARY_ADDR) begin
        rdata_next = pri_reg;
      end else if (bus_addr == CCC_SECONDARY_ADDR) begin
        rdata_next = sec_rd;
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  // all state registered; synchronous reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      div_reg   <= 16'h0000;
      pri_reg   <= CCC_PRIMARY_RST;
      // [RQ23] secondary cleared
      {amen_reg, aien_reg, tien_reg, ahit_reg} <= CCC_SECONDARY_RST[7:4];
      {phit_reg, hreq_reg} <= {CCC_SECONDARY_RST[3], CCC_SECONDARY_RST[0]};
      sub_reg   <= 16'h0000;
      carry_reg <= 1'b0;
      sinc_reg  <= 1'b0;
      hold_reg  <= CCC_HOLD_RUN;
      eq_reg    <= 1'b0;
      apend_reg <= 1'b0;
      hz_reg    <= 1'b0;
      cirq_reg  <= 1'b0;
      tirq_reg  <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      div_reg   <= div_next;
      pri_reg   <= pri_next;
      amen_reg  <= amen_next;
      aien_reg  <= aien_next;
      tien_reg  <= tien_next;
      ahit_reg  <= ahit_next;
      phit_reg  <= phit_next;
      hreq_reg  <= hreq_next;
      sub_reg   <= sub_next;
      carry_reg <= carry_next;
      sinc_reg  <= sinc_next;
      hold_reg  <= hold_next;
      eq_reg    <= eq_next;
      apend_reg <= apend_next;
      hz_reg    <= hz_next;
      cirq_reg  <= cirq_next;
      tirq_reg  <= tirq_next;
      rdata_reg <= rdata_next;
    end
  end

  // [RQ17] ack and freeze from state
  assign counters_frozen = (hold_reg != CCC_HOLD_RUN);
  assign seconds_inc     = sinc_reg;
  assign one_hz_pin      = hz_reg;
  assign clock_irq       = cirq_reg;
  assign trim_tick_irq   = tirq_reg;
  assign bus_rdata       = rdata_reg;

endmodule

// ==== dv/ccc_ctrl_asserts.sv ====
// port checker of the calendar clock control block
// assumes a bind onto ccc_calendar_ctrl, sync active high reset
`timescale 1ns/1ps
module ccc_ctrl_asserts
  import ccc_pkg::*;
#(
  parameter int SUB_DIV = 4
) (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [19:0] bus_addr,
  input wire logic        bus_wr,
  input wire logic [7:0]  bus_wdata,
  input wire logic        seconds_write,
  input wire logic        counter_write_busy,
  input wire logic        trim_tick,
  input wire logic        seconds_inc,
  input wire logic        counters_frozen,
  input wire logic        hour_format_sel,
  input wire logic        one_hz_pin,
  input wire logic        clock_irq,
  input wire logic        trim_tick_irq
);
  localparam int HOLD_MAX = SUB_DIV + 2;
  logic pri_wr, sec_wr, run_reg, run_next, hreq_reg, hreq_next;
  // byte writes only; bit writes are not shadowed
  assign pri_wr = bus_wr && bus_addr == CCC_PRIMARY_ADDR;
  assign sec_wr = bus_wr && bus_addr == CCC_SECONDARY_ADDR;
  // shadow of run with output enable, and of the hold request
  always_comb begin
    run_next  = pri_wr ? bus_wdata[7] & bus_wdata[5] : run_reg;
    hreq_next = sec_wr ? bus_wdata[0] : hreq_reg;
  end
  always_ff @(posedge core_clk) begin
    run_reg  <= sys_rst ? 1'h0 : run_next;
    hreq_reg <= sys_rst ? 1'h0 : hreq_next;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  rst_quiet_a: assert property (
    $past(sys_rst) |-> !(clock_irq | counters_frozen | one_hz_pin | seconds_inc))
    else $error("output active right after reset");
  trim_cause_a: assert property (
    trim_tick_irq |-> $past(trim_tick)) else $error("trim irq without tick");
  fmt_follow_a: assert property (
    $past(pri_wr) |-> hour_format_sel == $past(bus_wdata[3]))
    else $error("format bit not taken from write");
  hold_rise_a: assert property (
    sec_wr && bus_wdata[0] |-> ##[1:HOLD_MAX] counters_frozen)
    else $error("hold ack late");
  hold_busy_a: assert property (
    counters_frozen && counter_write_busy |=> counters_frozen)
    else $error("hold ack dropped while write pending");
  hold_drop_a: assert property (
    $fell(hreq_reg) && !counter_write_busy |-> ##[1:HOLD_MAX] !counters_frozen)
    else $error("hold ack did not drop");
  pin_stop_a: assert property (
    !run_reg && !$past(run_reg) |-> !one_hz_pin) else $error("pin active while off");
  secwr_quiet_a: assert property (
    seconds_write |-> ##2 !seconds_inc [*4]) else $error("carry kept after seconds write");
endmodule
bind ccc_calendar_ctrl ccc_ctrl_asserts #(.SUB_DIV(SUB_DIV)) i_chk (
  .core_clk           (core_clk),
  .sys_rst            (sys_rst),
  .bus_addr           (bus_addr),
  .bus_wr             (bus_wr),
  .bus_wdata          (bus_wdata),
  .seconds_write      (seconds_write),
  .counter_write_busy (counter_write_busy),
  .trim_tick          (trim_tick),
  .seconds_inc        (seconds_inc),
  .counters_frozen    (counters_frozen),
  .hour_format_sel    (hour_format_sel),
  .one_hz_pin         (one_hz_pin),
  .clock_irq          (clock_irq),
  .trim_tick_irq      (trim_tick_irq)
);

// ==== dv/ccc_calendar_ctrl_tb.sv ====
// self-checking bench of the calendar clock control block
// assumes a divider of 4 so that sub ticks come every 4 core cycles
`timescale 1ns/1ps
module ccc_calendar_ctrl_tb
  import ccc_pkg::*;
;
  localparam int DIV = 4;
  logic        core_clk = 0, sys_rst = 1, bus_wr = 0, bus_rd = 0, seconds_write = 0;
  logic        minute_carry = 0, hour_carry = 0, month_carry = 0, trim_tick = 0;
  logic        counter_write_busy = 0, precise_1hz = 0;
  logic        bus_bit_wr = 0;
  logic [2:0]  bus_bit_idx = 0;
  logic [19:0] bus_addr = 0;
  logic [7:0]  bus_wdata = 0, bus_rdata, rv;
  logic [6:0]  alarm_minute = 7'h06;
  logic [5:0]  cur_hour = 6'h10;
  logic        seconds_inc, counters_frozen, hour_format_sel, one_hz_pin;
  logic        clock_irq, trim_tick_irq;
  int          n_mismatch = 0, n_compared = 0, ci, ti;
  logic [31:0] per_tbl [10] = '{32'h83011001, 32'h84021001, 32'h86041001, 32'h87041001,
                                32'h8D020001, 32'h85021201, 32'h85023200, 32'h81071000,
                                32'h82071000, 32'h80071000};
  logic [15:0] pin_tbl [3] = '{16'hE001, 16'hC000, 16'h6000};
  // weekday and minute fixed; alarm hour follows the current hour
  ccc_calendar_ctrl #(.SUB_DIV(DIV)) i_dut (
    .core_clk           (core_clk),
    .sys_rst            (sys_rst),
    .bus_addr           (bus_addr),
    .bus_wr             (bus_wr),
    .bus_bit_wr         (bus_bit_wr),
    .bus_bit_idx        (bus_bit_idx),
    .bus_rd             (bus_rd),
    .bus_wdata          (bus_wdata),
    .bus_rdata          (bus_rdata),
    .cur_minute         (7'h05),
    .cur_hour           (cur_hour),
    .cur_weekday        (3'h2),
    .alarm_minute       (alarm_minute),
    .alarm_hour         (cur_hour),
    .alarm_weekday      (3'h2),
    .minute_carry       (minute_carry),
    .hour_carry         (hour_carry),
    .month_carry        (month_carry),
    .seconds_write      (seconds_write),
    .counter_write_busy (counter_write_busy),
    .precise_1hz        (precise_1hz),
    .trim_tick          (trim_tick),
    .seconds_inc        (seconds_inc),
    .counters_frozen    (counters_frozen),
    .hour_format_sel    (hour_format_sel),
    .one_hz_pin         (one_hz_pin),
    .clock_irq          (clock_irq),
    .trim_tick_irq      (trim_tick_irq)
  );
  // free running core clock
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [19:0] a, logic [7:0] d);
    @(negedge core_clk);
    bus_addr  = a;
    bus_wdata = d;
    bus_wr    = 1'h1;
    @(negedge core_clk);
    bus_wr    = 1'h0;
  endtask
  // single-bit write: bus_wdata[0] lands in bit i
  task automatic bwr(logic [19:0] a, logic [2:0] i, logic v);
    @(negedge core_clk);
    bus_addr    = a;
    bus_bit_idx = i;
    bus_wdata   = {7'h00, v};
    bus_bit_wr  = 1'h1;
    @(negedge core_clk);
    bus_bit_wr  = 1'h0;
  endtask
  // primary write under hold, hours rewritten before the hold is let go
  task automatic held_wr(logic [7:0] d, logic [5:0] h);
    wr(CCC_SECONDARY_ADDR, 8'h01);
    wr(CCC_PRIMARY_ADDR, d);
    cur_hour = h;
    wr(CCC_SECONDARY_ADDR, 8'h00);
  endtask
  task automatic rd(logic [19:0] a);
    @(negedge core_clk);
    bus_addr = a;
    bus_rd   = 1'h1;
    @(negedge core_clk);
    bus_rd   = 1'h0;
    rv       = bus_rdata;
  endtask
  // raise the chosen event inputs for one cycle, then count irq pulses
  task automatic ev(logic [3:0] m, int n);
    @(negedge core_clk);
    {trim_tick, month_carry, hour_carry, minute_carry} = m;
    ci = 0;
    ti = 0;
    repeat (n) begin
      @(negedge core_clk);
      {trim_tick, month_carry, hour_carry, minute_carry} = 4'h0;
      ci += (clock_irq === 1'h1);
      ti += (trim_tick_irq === 1'h1);
    end
  endtask
  task automatic t_regs();
    rd(CCC_PRIMARY_ADDR);
    chk("primary reset", rv, 8'h00);
    rd(CCC_SECONDARY_ADDR);
    chk("secondary reset", rv, 8'h00);
    rd(20'hFFF9F);
    chk("unmapped read", rv, 8'h00);
    bwr(CCC_SECONDARY_ADDR, 3'h5, 1'h1);
    rd(CCC_SECONDARY_ADDR);
    chk("bit write set", rv, 8'h20);
    bwr(CCC_SECONDARY_ADDR, 3'h5, 1'h0);
    rd(CCC_SECONDARY_ADDR);
    chk("bit write clear", rv, 8'h00);
    wr(CCC_PRIMARY_ADDR, 8'hFF);
    rd(CCC_PRIMARY_ADDR);
    chk("reserved bit", rv, 8'hEF);
    chk("format 24h", {7'h0, hour_format_sel}, 8'h01);
    held_wr(8'h00, cur_hour);
    chk("format 12h", {7'h0, hour_format_sel}, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_trim();
    wr(CCC_SECONDARY_ADDR, 8'h20);
    ev(4'h8, 3);
    chk("trim irq on", 8'(ti), 8'h01);
    wr(CCC_SECONDARY_ADDR, 8'h00);
    ev(4'h8, 3);
    chk("trim irq off", 8'(ti), 8'h00);
    $display("test trim done");
  endtask
  // every period code, the day code in both formats, and noon as a miss
  task automatic t_period();
    foreach (per_tbl[k]) begin
      held_wr(per_tbl[k][31:24], per_tbl[k][13:8]);
      ev(per_tbl[k][19:16], 4);
      chk("period irq", 8'(ci), per_tbl[k][7:0]);
      rd(CCC_SECONDARY_ADDR);
      chk("period flag", rv, {per_tbl[k][4:0], 3'h0});
      wr(CCC_SECONDARY_ADDR, 8'h08);
      rd(CCC_SECONDARY_ADDR);
      chk("flag keep", rv, {per_tbl[k][4:0], 3'h0});
      wr(CCC_SECONDARY_ADDR, 8'h00);
      rd(CCC_SECONDARY_ADDR);
      chk("flag clear", rv, 8'h00);
    end
    $display("test period done");
  endtask
  // alarm with and without its irq enable, match enable off while set up
  task automatic t_alarm();
    for (int e = 1; e >= 0; e--) begin
      wr(CCC_SECONDARY_ADDR, 8'h00);
      alarm_minute = 7'h06;
      wr(CCC_SECONDARY_ADDR, {1'h0, e[0], 6'h00});
      wr(CCC_SECONDARY_ADDR, {1'h1, e[0], 6'h00});
      ev(4'h0, 10);
      alarm_minute = 7'h05;
      ev(4'h0, 24);
      chk("alarm irq", 8'(ci), 8'(e));
      rd(CCC_SECONDARY_ADDR);
      chk("alarm flag", rv, {1'h1, e[0], 6'h10});
    end
    wr(CCC_SECONDARY_ADDR, 8'h00);
    $display("test alarm done");
  endtask
  task automatic t_hold();
    wr(CCC_SECONDARY_ADDR, 8'h01);
    ev(4'h0, DIV + 2);
    rd(CCC_SECONDARY_ADDR);
    chk("hold ack", rv, 8'h03);
    seconds_write = 1'h1;
    @(negedge core_clk);
    seconds_write = 1'h0;
    counter_write_busy = 1'h1;
    wr(CCC_SECONDARY_ADDR, 8'h00);
    ev(4'h0, 3 * DIV);
    chk("ack while busy", {7'h0, counters_frozen}, 8'h01);
    counter_write_busy = 1'h0;
    ev(4'h0, DIV + 2);
    chk("ack released", {7'h0, counters_frozen}, 8'h00);
    $display("test hold done");
  endtask
  task automatic t_pin();
    precise_1hz = 1'h1;
    foreach (pin_tbl[k]) begin
      wr(CCC_PRIMARY_ADDR, pin_tbl[k][15:8]);
      ev(4'h0, 4);
      chk("one hz pin", {7'h0, one_hz_pin}, pin_tbl[k][7:0]);
    end
    $display("test pin done");
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // main sequence after ten reset cycles
  initial begin
    repeat (10) @(negedge core_clk);
    sys_rst = 1'h0;
    t_regs();
    t_trim();
    t_period();
    t_alarm();
    t_hold();
    t_pin();
    print_verdict();
  end
  // watchdog well beyond the roughly 400 cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    print_verdict();
  end
endmodule
